// ---- core/ssb_pkg.sv ----
// package for the servo stop and brake sequencer
package ssb_pkg;
   localparam int unsigned SYS_CLK_HZ = 125000000;
   localparam int unsigned TICK_MS = 2;
   localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] LOW_SPEED_RPM = 16'd30;
   // register byte addresses
   localparam logic [7:0] ADDR_OFF_STOP = 8'h00;
   localparam logic [7:0] ADDR_STOP_BRK = 8'h04;
   localparam logic [7:0] ADDR_RUN_BRK = 8'h08;
   localparam logic [7:0] ADDR_REGEN = 8'h0c;
   localparam logic [7:0] ADDR_OVSPD1 = 8'h10;
   localparam logic [7:0] ADDR_TLIM2 = 8'h14;
   localparam logic [7:0] ADDR_OVFL2 = 8'h18;
   localparam logic [7:0] ADDR_OVSPD2 = 8'h1c;
   localparam logic [7:0] ADDR_ALM_STOP = 8'h20;
   localparam logic [7:0] ADDR_TLSW = 8'h24;
   localparam logic [7:0] ADDR_TLIM1 = 8'h28;
   localparam logic [7:0] ADDR_CTRL = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // reset values and the torque limit switch enable code
   localparam logic [15:0] RST_OFF_STOP = 16'h0000;
   localparam logic [15:0] RST_STOP_BRK = 16'h000a;
   localparam logic [15:0] RST_RUN_BRK = 16'h0032;
   localparam logic [15:0] RST_REGEN = 16'h0000;
   localparam logic [15:0] RST_OVSPD1 = 16'h0000;
   localparam logic [15:0] RST_TLIM2 = 16'h0064;
   localparam logic [15:0] RST_OVFL2 = 16'h0064;
   localparam logic [15:0] RST_OVSPD2 = 16'h0000;
   localparam logic [15:0] RST_ALM_STOP = 16'h0000;
   localparam logic [15:0] RST_TLSW = 16'h0000;
   localparam logic [15:0] RST_TLIM1 = 16'h012c;
   localparam logic [15:0] TLSW_ENABLE = 16'h0002;
   // control bits
   localparam int CTRL_SEL2 = 0;
   localparam int CTRL_ALM_RST = 1;
   // status bit positions, regen load limit and state codes
   localparam int ST_REGEN_ALM = 0;
   localparam int ST_OVSPD = 1;
   localparam int ST_OVFL = 2;
   localparam int ST_SERVO_ON = 3;
   localparam int ST_BRAKE = 4;
   localparam int ST_ALARM = 5;
   localparam int ST_STATE = 8;
   localparam logic [7:0] REGEN_LIMIT_PCT = 8'd10;
   typedef enum logic [2:0] {
      SSB_RUN = 3'b000,
      SSB_STOP_WAIT = 3'b001,
      SSB_DECEL = 3'b010,
      SSB_OFF = 3'b011,
      SSB_IDLE = 3'b100
   } ssb_state_t;
endpackage

// ---- core/ssb_seq.sv ----
// servo stop, brake interlock and protection sequencer with apb registers
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ssb_seq
   import ssb_pkg::*;
(
   input wire logic sys_clk, // 125 MHz clock
   input wire logic rst, // sync reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic run_cmd, // run command pin
   input wire logic main_power_ok, // main circuit power pin
   input wire logic alarm_in, // alarm from protection logic
   input wire logic [15:0] motor_speed, // speed magnitude r/min
   input wire logic [31:0] deviation, // deviation magnitude pulses
   input wire logic [7:0] regen_load_pct, // resistor loading percent
   output logic servo_on, // power stage enabled
   output logic dyn_brake, // dynamic brake on
   output logic brake_interlock_out, // brake release, high = released
   output logic dev_clear, // clear deviation counter
   output logic dev_hold, // hold deviation counter
   output logic ext_regen_en, // external regen circuit on
   output logic regen_alarm, // alarm 18
   output logic overspeed_err, // overspeed flag
   output logic overflow_err, // deviation overflow flag
   output logic [15:0] torque_limit // active limit percent
);
   import ssb_pkg::*;

   logic [15:0] off_stop, stop_brk, run_brk, regen, ovspd1, tlim2, ovfl2, ovspd2;
   logic [15:0] alm_stop, tlsw, tlim1;
   logic sel2, alm_rst;
   logic run_m, run_s, pwr_m, pwr_s;
   logic [15:0] next_off_stop, next_stop_brk, next_run_brk, next_regen, next_ovspd1;
   logic [15:0] next_tlim2, next_ovfl2, next_ovspd2, next_alm_stop, next_tlsw, next_tlim1;
   logic next_sel2, next_alm_rst;
   logic [31:0] rdata_c;
   logic err_c;
   logic wr;
   ssb_state_t state, next_state;
   logic alarm_lat, next_alarm_lat;

   // apb slave, zero wait states
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;

   always_comb begin
      next_off_stop = off_stop;
      next_stop_brk = stop_brk;
      next_run_brk = run_brk;
      next_regen = regen;
      next_ovspd1 = ovspd1;
      next_tlim2 = tlim2;
      next_ovfl2 = ovfl2;
      next_ovspd2 = ovspd2;
      next_alm_stop = alm_stop;
      next_tlsw = tlsw;
      next_tlim1 = tlim1;
      next_sel2 = sel2;
      next_alm_rst = 1'b0;
      rdata_c = 32'h0;
      err_c = 1'b0;
      if (paddr == ADDR_OFF_STOP) begin
         rdata_c = {16'h0, off_stop};
         if (wr) next_off_stop = pwdata[15:0];
      end else if (paddr == ADDR_STOP_BRK) begin
         rdata_c = {16'h0, stop_brk};
         if (wr) next_stop_brk = pwdata[15:0];
      end else if (paddr == ADDR_RUN_BRK) begin
         rdata_c = {16'h0, run_brk};
         if (wr) next_run_brk = pwdata[15:0];
      end else if (paddr == ADDR_REGEN) begin
         rdata_c = {16'h0, regen};
         if (wr) next_regen = pwdata[15:0];
      end else if (paddr == ADDR_OVSPD1) begin
         rdata_c = {16'h0, ovspd1};
         if (wr) next_ovspd1 = pwdata[15:0];
      end else if (paddr == ADDR_TLIM2) begin
         rdata_c = {16'h0, tlim2};
         if (wr) next_tlim2 = pwdata[15:0];
      end else if (paddr == ADDR_OVFL2) begin
         rdata_c = {16'h0, ovfl2};
         if (wr) next_ovfl2 = pwdata[15:0];
      end else if (paddr == ADDR_OVSPD2) begin
         rdata_c = {16'h0, ovspd2};
         if (wr) next_ovspd2 = pwdata[15:0];
      end else if (paddr == ADDR_ALM_STOP) begin
         rdata_c = {16'h0, alm_stop};
         if (wr) next_alm_stop = pwdata[15:0];
      end else if (paddr == ADDR_TLSW) begin
         rdata_c = {16'h0, tlsw};
         if (wr) next_tlsw = pwdata[15:0];
      end else if (paddr == ADDR_TLIM1) begin
         rdata_c = {16'h0, tlim1};
         if (wr) next_tlim1 = pwdata[15:0];
      end else if (paddr == ADDR_CTRL) begin
         rdata_c = {31'h0, sel2};
         if (wr) begin
            next_sel2 = pwdata[CTRL_SEL2];
            next_alm_rst = pwdata[CTRL_ALM_RST];
         end
      end else if (paddr == ADDR_STATUS) begin
         rdata_c = {16'h0, 5'h0, state, 2'h0, alarm_lat, brake_interlock_out, servo_on,
                    overflow_err, overspeed_err, regen_alarm};
      end else begin
         err_c = 1'b1;
      end
   end

   assign pslverr = psel && penable && err_c;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         off_stop <= RST_OFF_STOP;
         stop_brk <= RST_STOP_BRK;
         run_brk <= RST_RUN_BRK;
         regen <= RST_REGEN;
         ovspd1 <= RST_OVSPD1;
         tlim2 <= RST_TLIM2;
         ovfl2 <= RST_OVFL2;
         ovspd2 <= RST_OVSPD2;
         alm_stop <= RST_ALM_STOP;
         tlsw <= RST_TLSW;
         tlim1 <= RST_TLIM1;
         sel2 <= 1'b0;
         alm_rst <= 1'b0;
         prdata <= 32'h0;
         run_m <= 1'b0;
         run_s <= 1'b0;
         pwr_m <= 1'b0;
         pwr_s <= 1'b0;
      end else begin
         off_stop <= next_off_stop;
         stop_brk <= next_stop_brk;
         run_brk <= next_run_brk;
         regen <= next_regen;
         ovspd1 <= next_ovspd1;
         tlim2 <= next_tlim2;
         ovfl2 <= next_ovfl2;
         ovspd2 <= next_ovspd2;
         alm_stop <= next_alm_stop;
         tlsw <= next_tlsw;
         tlim1 <= next_tlim1;
         sel2 <= next_sel2;
         alm_rst <= next_alm_rst;
         prdata <= (psel && !penable) ? rdata_c : prdata;
         run_m <= run_cmd;
         run_s <= run_m;
         pwr_m <= main_power_ok;
         pwr_s <= pwr_m;
      end
   end

   // 2 ms tick and delay counting
   logic [17:0] div_cnt, next_div_cnt;
   logic tick;
   assign tick = (div_cnt == 18'(TICK_CYCLES - 1));
   always_comb begin
      next_div_cnt = tick ? 18'h0 : div_cnt + 18'h1;
   end

   logic [15:0] dly, next_dly;
   logic use_alm, next_use_alm;
   logic [2:0] code;
   logic still, sw_en;

   assign still = (motor_speed <= LOW_SPEED_RPM);
   // alarm uses alarm stop code, deviation held until alarm reset clears it
   assign code = use_alm ? {1'b1, alm_stop[1:0]} : off_stop[2:0];

   always_comb begin
      next_state = state;
      next_dly = dly;
      next_alarm_lat = alarm_lat;
      next_use_alm = use_alm;
      if (alarm_in) next_alarm_lat = 1'b1;
      else if (alm_rst) next_alarm_lat = 1'b0;
      case (state)
         SSB_IDLE: begin
            if (run_s && !alarm_lat && pwr_s) next_state = SSB_RUN;
         end
         SSB_RUN: begin
            // run drop or alarm starts a stop
            if (!run_s || alarm_in || alarm_lat || !pwr_s) begin
               next_use_alm = alarm_in || alarm_lat;
               next_dly = 16'h0;
               if (!still) next_state = SSB_DECEL;
               else if (alarm_in || alarm_lat) next_state = SSB_OFF;
               else next_state = SSB_STOP_WAIT;
            end
         end
         SSB_STOP_WAIT: begin
            // zero setting means no delay
            // alarm skips the brake delay
            if (alarm_in || alarm_lat) begin
               next_state = SSB_OFF;
               next_use_alm = 1'b1;
            end else if (dly >= stop_brk) begin
               next_state = SSB_OFF;
            end else if (tick) begin
               next_dly = dly + 16'h1;
            end
         end
         SSB_DECEL: begin
            // shorter of delay or low speed
            if (dly >= run_brk || still) next_state = SSB_OFF;
            else if (tick) next_dly = dly + 16'h1;
         end
         SSB_OFF: begin
            if (still && !alarm_lat) begin
               next_state = SSB_IDLE;
               next_use_alm = 1'b0;
            end
         end
         default: next_state = SSB_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt <= 18'h0;
         state <= SSB_IDLE;
         dly <= 16'h0;
         alarm_lat <= 1'b0;
         use_alm <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         state <= next_state;
         dly <= next_dly;
         alarm_lat <= next_alarm_lat;
         use_alm <= next_use_alm;
      end
   end

   // outputs of the stop sequence
   logic next_servo_on, next_db, next_bk, next_clr, next_hold;
   logic next_ext, next_regen_alm, next_ovs, next_ovf;
   logic [15:0] next_tl;
   logic use2;
   // second set only with switching enabled
   assign sw_en = (tlsw == TLSW_ENABLE);
   assign use2 = sw_en && sel2;

   always_comb begin
      // stage off in decel, braking or free running
      next_servo_on = (state == SSB_RUN) || (state == SSB_STOP_WAIT);
      next_bk = (state == SSB_RUN) || (state == SSB_DECEL);
      next_db = 1'b0;
      next_clr = 1'b0;
      next_hold = 1'b0;
      if (state == SSB_DECEL) next_db = !code[0];
      if (state == SSB_OFF || state == SSB_IDLE) next_db = !code[1];
      if (state != SSB_RUN) begin
         next_clr = !code[2];
         next_hold = code[2];
      end
      if (alm_rst && use_alm) begin
         next_clr = 1'b1;
         next_hold = 1'b0;
      end
      if (!pwr_s) next_db = 1'b1;
      // capacitor only for 0 and 3
      next_ext = (regen[1:0] == 2'd1) || (regen[1:0] == 2'd2);
      // alarm 18 only for code 1, sticky; never for code 2
      next_regen_alm = regen_alarm && !alm_rst;
      if (regen[1:0] == 2'd1 && regen_load_pct > REGEN_LIMIT_PCT) next_regen_alm = 1'b1;
      next_ovs = sw_en && (use2 ? (motor_speed > ovspd2) : (motor_speed > ovspd1));
      next_ovf = use2 && (deviation > {1'b0, ovfl2[14:0], 8'h0});
      next_tl = use2 ? tlim2 : tlim1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         servo_on <= 1'b0;
         dyn_brake <= 1'b1;
         brake_interlock_out <= 1'b0;
         dev_clear <= 1'b0;
         dev_hold <= 1'b0;
         ext_regen_en <= 1'b0;
         regen_alarm <= 1'b0;
         overspeed_err <= 1'b0;
         overflow_err <= 1'b0;
         torque_limit <= RST_TLIM1;
      end else begin
         servo_on <= next_servo_on;
         dyn_brake <= next_db;
         brake_interlock_out <= next_bk;
         dev_clear <= next_clr;
         dev_hold <= next_hold;
         ext_regen_en <= next_ext;
         regen_alarm <= next_regen_alm;
         overspeed_err <= next_ovs;
         overflow_err <= next_ovf;
         torque_limit <= next_tl;
      end
   end
endmodule

// ---- dv/ssb_chk.sv ----
// assertion checker for the stop and brake sequencer
`timescale 1ns/1ps
module ssb_chk
   import ssb_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic rst, // sync reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic main_power_ok, // power pin
   input wire logic alarm_in, // alarm
   input wire logic servo_on, // stage on
   input wire logic dyn_brake, // dyn brake
   input wire logic brake_interlock_out, // brake release
   input wire logic ext_regen_en, // ext regen
   input wire logic regen_alarm, // alarm 18
   input wire logic overspeed_err // overspeed
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   logic [15:0] tlsw_q, regen_q, next_tlsw, next_regen;
   logic wr, tl_off, rg_in, rg_one;
   assign wr = psel && penable && pwrite && pready;
   assign tl_off = tlsw_q != TLSW_ENABLE;
   assign rg_in = regen_q == 16'h0 || regen_q == 16'h3;
   assign rg_one = regen_q == 16'h1;
   // shadow copies of the switch and regen settings
   always_comb begin
      next_tlsw = tlsw_q;
      next_regen = regen_q;
      if (wr && paddr == ADDR_TLSW) next_tlsw = pwdata[15:0];
      if (wr && paddr == ADDR_REGEN) next_regen = pwdata[15:0];
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tlsw_q <= 16'h0;
         regen_q <= 16'h0;
      end else begin
         tlsw_q <= next_tlsw;
         regen_q <= next_regen;
      end
   end
   a_reset_state: assert property ($fell(rst) |->
         !servo_on && dyn_brake && !brake_interlock_out)
      else $error("outputs not at reset state");
   a_bad_addr: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
      else $error("unmapped access without error");
   a_power_brake: assert property (!main_power_ok [*4] |-> dyn_brake)
      else $error("no dynamic brake without power");
   a_brake_start: assert property ($rose(brake_interlock_out) |-> servo_on)
      else $error("brake released with servo off");
   a_switch_off: assert property (tl_off && $past(tl_off) && $past(tl_off, 2)
         |-> !overspeed_err)
      else $error("overspeed with switching off");
   a_regen_inside: assert property (rg_in && $past(rg_in) && $past(rg_in, 2)
         |-> !ext_regen_en)
      else $error("external regen on with capacitor code");
   a_regen_quiet: assert property (!rg_one && !$past(rg_one) && !$past(rg_one, 2)
         |-> !$rose(regen_alarm))
      else $error("regen alarm raised outside code one");
   a_alarm_stop: assert property (alarm_in [*5] |-> !servo_on)
      else $error("servo on during alarm");
   a_spin_up: assert property ($rose(servo_on) && $past(main_power_ok, 3) |-> !dyn_brake)
      else $error("dynamic brake at servo on");
   c_run: cover property ($rose(servo_on));
   c_regen: cover property ($rose(regen_alarm));
   c_ovs: cover property ($rose(overspeed_err));
endmodule
bind ssb_seq ssb_chk u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .main_power_ok, .alarm_in, .servo_on, .dyn_brake, .brake_interlock_out,
   .ext_regen_en, .regen_alarm, .overspeed_err);

// ---- dv/ssb_host.sv ----
// host controller model driving the run command
`timescale 1ns/1ps
module ssb_host (
   input wire logic sys_clk, // clock
   input wire logic rst, // sync reset
   input wire logic want, // wanted run level
   input wire logic [3:0] lag, // reply delay cycles
   output logic run_cmd // run command pin
);
   logic [3:0] cnt;
   always_ff @(posedge sys_clk) begin
      if (rst || want == run_cmd) begin
         cnt <= 4'h0;
         run_cmd <= rst ? 1'b0 : run_cmd;
      end else if (cnt >= lag) begin
         cnt <= 4'h0;
         run_cmd <= want;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// ---- dv/ssb_seq_tb.sv ----
// self-checking bench for the stop and brake sequencer
`timescale 1ns/1ps
module ssb_seq_tb;
   import ssb_pkg::*;
   typedef struct packed {
      logic [15:0] tlsw;
      logic sel2;
      logic [15:0] spd;
      logic [31:0] dev;
      logic ovs;
      logic ovf;
      logic [15:0] tl;
   } ssb_row_t;
   localparam ssb_row_t ROWS [6] = '{
      '{16'h2, 1'b0, 16'h96, 32'h0, 1'b1, 1'b0, 16'h12c},
      '{16'h2, 1'b0, 16'h64, 32'h0, 1'b0, 1'b0, 16'h12c},
      '{16'h2, 1'b1, 16'h96, 32'h6401, 1'b0, 1'b1, 16'h64},
      '{16'h2, 1'b1, 16'hc9, 32'h6400, 1'b1, 1'b0, 16'h64},
      '{16'h0, 1'b1, 16'h12c, 32'h0, 1'b0, 1'b0, 16'h12c},
      '{16'h1, 1'b1, 16'h12c, 32'h0, 1'b0, 1'b0, 16'h12c}};
   localparam logic [15:0] RSTV [8] = '{16'h0, 16'ha, 16'h32, 16'h0, 16'h0, 16'h64, 16'h64, 16'h0};
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0, regen_load_pct = 8'h0;
   logic [31:0] pwdata = 32'h0, deviation = 32'h0, prdata, q_rd;
   logic pready, pslverr, run_cmd, want = 1'b0, main_power_ok = 1'b1, alarm_in = 1'b0, q_err;
   logic [3:0] lag = 4'h0;
   logic [15:0] motor_speed = 16'h0, torque_limit;
   logic servo_on, dyn_brake, brake_interlock_out, dev_clear, dev_hold, ext_regen_en;
   logic regen_alarm, overspeed_err, overflow_err;
   int fails = 0, checks = 0;
   always #4 sys_clk = ~sys_clk;
   ssb_seq dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .run_cmd, .main_power_ok, .alarm_in, .motor_speed, .deviation, .regen_load_pct,
      .servo_on, .dyn_brake, .brake_interlock_out, .dev_clear, .dev_hold, .ext_regen_en,
      .regen_alarm, .overspeed_err, .overflow_err, .torque_limit);
   ssb_host host (.sys_clk, .rst, .want, .lag, .run_cmd);
   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q_rd = prdata;
      q_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fails++;
         close_out();
      end
      @(posedge sys_clk);
   endtask
   // waits for the brake release output to reach a level
   task wait_for(input logic v);
      int n;
      n = 0;
      while (brake_interlock_out !== v && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 400) begin
         fails++;
         close_out();
      end
   endtask
   initial begin
      tick(3);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(q_rd, {16'h0, RSTV[i]});
      end
      apb(1'b0, 8'h3c, 32'h0);
      check(q_err, 1'b1);
      check(q_rd, 32'h0);
      apb(1'b1, ADDR_OVSPD1, 32'h64);
      apb(1'b1, ADDR_OVSPD2, 32'hc8);
      foreach (ROWS[i]) begin
         apb(1'b1, ADDR_TLSW, {16'h0, ROWS[i].tlsw});
         apb(1'b1, ADDR_CTRL, {31'h0, ROWS[i].sel2});
         motor_speed <= ROWS[i].spd;
         deviation <= ROWS[i].dev;
         tick(5);
         check(overspeed_err, ROWS[i].ovs);
         check(overflow_err, ROWS[i].ovf);
         check(torque_limit, ROWS[i].tl);
      end
      motor_speed <= 16'h0;
      apb(1'b1, ADDR_RUN_BRK, 32'h64);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_OFF_STOP, 32'(c));
         lag <= 4'(c);
         want <= 1'b1;
         wait_for(1'b1);
         motor_speed <= 16'h3e8;
         want <= 1'b0;
         tick(c + 8);
         check(dyn_brake, !c[0]);
         check(brake_interlock_out, 1'b1);
         motor_speed <= 16'h14;
         wait_for(1'b0);
         tick(3);
         check(dyn_brake, !c[1]);
         check({dev_clear, dev_hold}, {!c[2], c[2]});
         tick(3);
      end
      apb(1'b1, ADDR_STOP_BRK, 32'h0);
      motor_speed <= 16'h0;
      want <= 1'b1;
      wait_for(1'b1);
      want <= 1'b0;
      wait_for(1'b0);
      check(servo_on, 1'b1);
      tick(4);
      check(servo_on, 1'b0);
      for (int r = 0; r < 4; r++) begin
         regen_load_pct <= 8'h0;
         apb(1'b1, ADDR_CTRL, 32'h2);
         apb(1'b1, ADDR_REGEN, 32'(r));
         regen_load_pct <= (r == 1) ? 8'ha : 8'h32;
         tick(5);
         check(regen_alarm, 1'b0);
         regen_load_pct <= 8'h32;
         tick(5);
         check(ext_regen_en, r == 1 || r == 2);
         check(regen_alarm, r == 1);
      end
      regen_load_pct <= 8'h0;
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_ALM_STOP, 32'h1);
      want <= 1'b1;
      wait_for(1'b1);
      alarm_in <= 1'b1;
      tick(8);
      check({servo_on, dev_hold, dyn_brake}, 3'b011);
      alarm_in <= 1'b0;
      want <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h2);
      tick(1);
      check(dev_clear, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(q_rd[ST_ALARM], 1'b0);
      tick(4);
      want <= 1'b1;
      wait_for(1'b1);
      main_power_ok <= 1'b0;
      tick(8);
      check({dyn_brake, servo_on}, 2'b10);
      main_power_ok <= 1'b1;
      want <= 1'b0;
      tick(4);
      // mid-run reset back to defaults
      rst <= 1'b1;
      tick(3);
      check({servo_on, dyn_brake, brake_interlock_out}, 3'b010);
      rst <= 1'b0;
      apb(1'b0, ADDR_RUN_BRK, 32'h0);
      check(q_rd, {16'h0, RST_RUN_BRK});
      close_out();
   end
endmodule
